// ==== verilog/pbsp_pkg.sv ====
// pbsp_pkg: shared constants and carrier types for the burst sram port.
// assumes a single synchronous clock domain; no software registers.
package pbsp_pkg;
    localparam int PBSP_LANE_W     = 9;
    localparam int PBSP_LANES_X36  = 4;
    localparam int PBSP_AW_X36     = 18;
    localparam int PBSP_BURST_W    = 2;
    localparam logic [1:0] PBSP_BURST_START = 2'h0;
    localparam logic       PBSP_ORDER_LINEAR = 1'h1;
    localparam int PBSP_CLK_MHZ    = 25;

    typedef struct packed {
        logic adv;
        logic we;
        logic sel;
    } pbsp_ctl_t;
endpackage : pbsp_pkg

// ==== verilog/pbsp_mem.sv ====
// pbsp_mem: word array with byte-lane write and registered read data.
// assumes the caller qualifies every access with its own enable; a write
// and a read may fall in one cycle, the read then sees the old word.
`timescale 1ns/100ps
module pbsp_mem #(
    parameter int AW    = 18,
    parameter int LANES = 4,
    parameter int LW    = 9
) (
    input  wire logic                  clk,
    input  wire logic                  we,
    input  wire logic [LANES-1:0]      lane_we,
    input  wire logic [AW-1:0]         waddr,
    input  wire logic [LANES*LW-1:0]   wdata,
    input  wire logic                  re,
    input  wire logic [AW-1:0]         raddr,
    output logic      [LANES*LW-1:0]   rdata
);
    // one bank per lane keeps every array under a single writer; read
    // data held in a register; content survives a stopped clock
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LW-1:0] bank [0:(1<<AW)-1];
            always_ff @(posedge clk) begin
                if (we && lane_we[g]) begin
                    bank[waddr] <= wdata[g*LW +: LW]; // RULE_13
                end
                if (re) begin
                    rdata[g*LW +: LW] <= bank[raddr];
                end
            end
        end
    endgenerate
endmodule : pbsp_mem

// ==== verilog/pbsp_port.sv ====
// pbsp_port: pipelined burst sram port, flow-through-free late-write style.
// assumes controller drives write data for the third edge after the
// write command, the slot in which a read word would stand on the bus.
`timescale 1ns/100ps
// What this block does
// RULE_01: array 256K x 36 or 512K x 18
// RULE_02: all inputs registered on rising edge; output_enable_n and burst_order_linear are used unregistered
// RULE_03: read data from output registers
// RULE_04: qualify high stalls whole pipeline
// RULE_05: back to back reads writes, no turnaround
// RULE_06: zero wait states
// RULE_07: writes self-timed internally
// RULE_08: drivers off during write data phase
// RULE_09: output enable self-timed internally
// RULE_10: three selects; async output enable
// RULE_11: linear or interleaved burst order
// RULE_12: sleep input; state kept clock stopped
// RULE_13: byte enables gate 9-bit lanes
// RULE_14: burst counter from two low bits
module pbsp_port
    import pbsp_pkg::*;
#(
    parameter int AW    = PBSP_AW_X36,
    parameter int LANES = PBSP_LANES_X36
) (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         clock_qualify_n,
    input  wire logic                         chip_select_first_n,
    input  wire logic                         chip_select_second,
    input  wire logic                         chip_select_third_n,
    input  wire logic                         write_n,
    input  wire logic                         burst_advance_or_load,
    input  wire logic [LANES-1:0]             byte_lane_write_n,
    input  wire logic [AW-1:0]                addr,
    input  wire logic                         burst_order_linear,
    input  wire logic                         output_enable_n,
    input  wire logic                         sleep_request,
    input  wire logic [LANES*PBSP_LANE_W-1:0] data_in,
    output logic      [LANES*PBSP_LANE_W-1:0] data_out,
    output logic                              data_oe
);
    localparam int DW = LANES*PBSP_LANE_W;

    logic              run;
    pbsp_ctl_t         ctl_r;
    logic [AW-1:0]     addr_r;
    logic [LANES-1:0]  bw_r;
    logic [DW-1:0]     din_r;
    logic [1:0]        bcnt_r;
    logic [1:0]        bcnt_nxt;
    logic [1:0]        bofs;
    logic [AW-1:0]     cur_addr;
    logic              cur_we_r;
    logic              cur_act_r;
    logic              rd_ph1_r;
    logic              wr_ph1_r;
    logic              wr_ph2_r;
    logic              wr_ph3_r;
    logic [AW-1:0]     wa1_r;
    logic [AW-1:0]     wa2_r;
    logic [AW-1:0]     wa3_r;
    logic [LANES-1:0]  wb1_r;
    logic [LANES-1:0]  wb2_r;
    logic [LANES-1:0]  wb3_r;
    logic [AW-1:0]     base_r;
    logic [DW-1:0]     rdata;
    logic              sleep_r;
    logic              mem_en;
    logic              mem_wr;
    logic [AW-1:0]     mem_addr;

    // sleep forces a stall; clock stopping needs nothing, all state static
    assign run = !clock_qualify_n && !sleep_r; // RULE_04 RULE_12

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleep_r <= 1'h0;
        end else begin
            sleep_r <= sleep_request; // RULE_12
        end
    end

    // input capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_r  <= '0;
            addr_r <= '0;
            bw_r   <= '0;
            din_r  <= '0;
        end else if (run) begin // RULE_04
            ctl_r.sel <= !chip_select_first_n && chip_select_second
                         && !chip_select_third_n; // RULE_10
            ctl_r.we  <= !write_n;
            ctl_r.adv <= burst_advance_or_load;
            addr_r    <= addr; // RULE_02
            bw_r      <= ~byte_lane_write_n;
            din_r     <= data_in; // RULE_02
        end
    end

    // burst sequencing: load on any cycle with advance low, advance on continue
    always_comb begin
        bcnt_nxt = bcnt_r + 2'h1;
        if (!ctl_r.adv) begin
            bcnt_nxt = PBSP_BURST_START;
        end
        if (burst_order_linear == PBSP_ORDER_LINEAR) begin
            bofs = base_r[1:0] + bcnt_nxt; // RULE_11
        end else begin
            bofs = base_r[1:0] ^ bcnt_nxt; // RULE_11
        end
        if (!ctl_r.adv) begin
            bofs = addr_r[1:0]; // RULE_14
        end
        cur_addr = ctl_r.adv ? base_r : addr_r;
        cur_addr[PBSP_BURST_W-1:0] = bofs; // RULE_14
    end

    // command stage; a continue inherits the direction of its burst
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bcnt_r    <= '0;
            base_r    <= '0;
            cur_we_r  <= 1'h0;
            cur_act_r <= 1'h0;
        end else if (run) begin
            bcnt_r <= bcnt_nxt; // RULE_14
            if (!ctl_r.adv) begin
                base_r    <= addr_r;
                cur_we_r  <= ctl_r.we;
                cur_act_r <= ctl_r.sel; // RULE_10
            end
        end
    end

    logic op_act;
    logic op_we;
    assign op_act = ctl_r.adv ? cur_act_r : ctl_r.sel;
    assign op_we  = ctl_r.adv ? cur_we_r  : ctl_r.we;

    // data phase pipeline: reads and writes share one schedule, so any
    // mix runs back to back with no idle cycle. active edges, counted
    // from the edge that captures the command:
    //   edge 1  array read starts; write address enters stage one
    //   edge 2  read word reaches the output register and the pins
    //   edge 3  write data sampled, the slot a read word would occupy
    //   edge 4  write lands in the array
    // read and write words thus meet the bus in the same cycle slot,
    // which is what removes any turnaround between them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ph1_r <= 1'h0;
            wr_ph1_r <= 1'h0;
            wr_ph2_r <= 1'h0;
            wr_ph3_r <= 1'h0;
        end else if (run) begin // RULE_05 RULE_06
            rd_ph1_r <= op_act && !op_we;
            wr_ph1_r <= op_act && op_we;
            wr_ph2_r <= wr_ph1_r;
            wr_ph3_r <= wr_ph2_r;
        end
    end

    // write address and lane enables follow their command down the pipe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wa1_r <= '0;
            wa2_r <= '0;
            wa3_r <= '0;
            wb1_r <= '0;
            wb2_r <= '0;
            wb3_r <= '0;
        end else if (run) begin
            wa1_r <= cur_addr;
            wa2_r <= wa1_r;
            wa3_r <= wa2_r;
            wb1_r <= bw_r;
            wb2_r <= wb1_r;
            wb3_r <= wb2_r;
        end
    end

    // separate write and read sides: a read never waits behind a write
    // that is committing; a read of a word still in the write pipe
    // returns the old contents
    assign mem_wr   = run && wr_ph3_r; // RULE_07
    assign mem_en   = run && op_act && !op_we;
    assign mem_addr = cur_addr;

    pbsp_mem #(
        .AW    (AW),
        .LANES (LANES),
        .LW    (PBSP_LANE_W)
    ) u_mem (
        .clk     (clk),
        .we      (mem_wr),
        .lane_we (wb3_r),
        .waddr   (wa3_r),
        .wdata   (din_r),
        .re      (mem_en),
        .raddr   (mem_addr),
        .rdata   (rdata)
    ); // RULE_01

    // output register and self-timed driver enable; the word changes
    // only when a read arrives, so the pins keep the last read word
    logic [DW-1:0] rd_hold_r;
    logic          oe_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_hold_r <= '0;
            oe_r      <= 1'h0;
        end else if (run) begin
            if (rd_ph1_r) begin
                rd_hold_r <= rdata; // RULE_03
            end
            oe_r <= rd_ph1_r && !wr_ph1_r; // RULE_08 RULE_09
        end
    end

    assign data_out = rd_hold_r;
    assign data_oe  = oe_r && !output_enable_n; // RULE_10
endmodule : pbsp_port

// ==== dv/pbsp_port_assertions.sv ====
// pbsp_port_assertions: pipeline timing checks on the port pins.
// bound into pbsp_port; sleep acts as a stall one edge late.
`timescale 1ns/100ps
module pbsp_port_assertions #(
    parameter int DW = 36
) (
    input wire logic          clk,
    input wire logic          nrst,
    input wire logic          clock_qualify_n,
    input wire logic          chip_select_first_n,
    input wire logic          chip_select_second,
    input wire logic          chip_select_third_n,
    input wire logic          write_n,
    input wire logic          burst_advance_or_load,
    input wire logic          output_enable_n,
    input wire logic          sleep_request,
    input wire logic [DW-1:0] data_out,
    input wire logic          data_oe
);
    logic slp_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) slp_r <= 1'h0;
        else slp_r <= sleep_request;
    end
    wire sel = !chip_select_first_n && chip_select_second;
    wire act = !clock_qualify_n && !sleep_request && !slp_r;
    wire go  = act && sel && !chip_select_third_n && !burst_advance_or_load;
    wire idl = act && !(sel && !chip_select_third_n);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_oe_gate: assert property (output_enable_n |-> !data_oe)
        else $error("drive enable high while output enable is off");
    a_stall_data: assert property (
        clock_qualify_n |=> $stable(data_out))
        else $error("read data moved on a stalled edge");
    a_stall_drive: assert property (
        clock_qualify_n && !output_enable_n ##1 !output_enable_n
        |-> $stable(data_oe)) else $error("drive moved while stalled");
    a_sleep_hold: assert property (
        sleep_request[*2] |=> $stable(data_out))
        else $error("read data moved while asleep");
    a_write_off: assert property (
        go && !write_n ##1 act[*2] |=> !data_oe)
        else $error("drivers on during write data");
    a_read_drive: assert property (
        go && write_n ##1 act[*3] ##0 !output_enable_n |-> ##[0:1] data_oe)
        else $error("read data never driven");
    a_desel_quiet: assert property (
        (idl && !burst_advance_or_load)[*6] |-> !data_oe)
        else $error("drive while deselected");
    a_burst_stream: assert property (
        go && write_n ##1 (act && burst_advance_or_load)[*3] ##1 act[*2]
        ##0 !output_enable_n |-> data_oe) else $error("gap in burst");
    c_read: cover property (go && write_n);
    c_write: cover property (go && !write_n);
    c_stall: cover property (clock_qualify_n[*3]);
endmodule : pbsp_port_assertions
bind pbsp_port pbsp_port_assertions #(.DW(LANES*pbsp_pkg::PBSP_LANE_W))
    u_chk (.*);

// ==== dv/pbsp_ctl_model.sv ====
// pbsp_ctl_model: external controller, drives pins at falling edges.
// assumes write data is taken three active edges after its command.
`timescale 1ns/100ps
module pbsp_ctl_model (
    input  wire logic  clk,
    output logic       clock_qualify_n,
    output logic       chip_select_first_n,
    output logic       chip_select_second,
    output logic       chip_select_third_n,
    output logic       write_n,
    output logic       burst_advance_or_load,
    output logic [3:0] byte_lane_write_n,
    output logic [3:0] addr,
    output logic       sleep_request,
    output logic [35:0] data_in
);
    logic [36:0] wp0, wp1, wp2;
    logic [35:0] wd;
    initial {clock_qualify_n, chip_select_first_n, chip_select_second} = 0;
    initial {chip_select_third_n, burst_advance_or_load, sleep_request} = 0;
    initial {write_n, byte_lane_write_n, addr, data_in, wd} = '1;
    // only single writes are queued; sleep is never used with writes
    always @(posedge clk) if (!clock_qualify_n) begin
        wp0 <= {!write_n && chip_select_second && !burst_advance_or_load, wd};
        wp1 <= wp0;
        wp2 <= wp1;
    end
    // idle data toggles so a stale word never looks valid
    always @(negedge clk) data_in <= wp2[36] === 1'h1 ? wp2[35:0] : ~data_in;
    task automatic cmd(input logic w_n, adv, input logic [3:0] a, ben_n,
                       input logic [35:0] d);
        {chip_select_second, write_n, burst_advance_or_load} = {1'h1, w_n, adv};
        {addr, byte_lane_write_n, wd} = {a, ben_n, d};
        @(negedge clk);
    endtask : cmd
    task automatic idle();
        {chip_select_second, burst_advance_or_load} = 2'h0;
    endtask : idle
    task automatic stall(input int n, input logic slp);
        {sleep_request, clock_qualify_n} = {slp, !slp};
        repeat (n) @(negedge clk);
        {sleep_request, clock_qualify_n} = 2'h0;
    endtask : stall
endmodule : pbsp_ctl_model

// ==== dv/pbsp_port_tb_top.sv ====
// pbsp_port_tb_top: directed scenarios for the burst sram port.
// assumes pbsp_ctl_model drives every command and write-data pin.
`timescale 1ns/100ps
module pbsp_port_tb_top;
    logic clk, nrst, clock_qualify_n, chip_select_first_n, chip_select_second;
    logic chip_select_third_n, write_n, burst_advance_or_load, sleep_request;
    logic burst_order_linear, output_enable_n, data_oe;
    logic [3:0] byte_lane_write_n, addr;
    logic [35:0] data_in, data_out, exp_q[$];
    int num_errors = 0, checks_done = 0;
    pbsp_port #(.AW(4), .LANES(4)) dut (.*);
    pbsp_ctl_model ctl (.*);
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    function automatic logic [35:0] pat(input int i);
        return 36'hC_3A50_F000 + 36'(i * 17);
    endfunction : pat
    task automatic check(input logic [35:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic collect();
        repeat (16) begin
            @(negedge clk);
            if (data_oe === 1'h1 && exp_q.size() > 0)
                check(data_out, exp_q.pop_front());
        end
        check(36'(exp_q.size()), 36'h0);
    endtask : collect
    task automatic t_rw();
        fork
            collect();
            begin
                for (int i = 0; i < 4; i++) ctl.cmd(0, 0, 4'(i), 4'h0, pat(i));
                for (int i = 0; i < 4; i++) begin
                    exp_q.push_back(pat(i));
                    ctl.cmd(1'h1, 1'h0, 4'(i), 4'hF, 36'h0);
                end
                ctl.idle();
            end
        join
    endtask : t_rw
    task automatic t_lane();
        exp_q.push_back(36'hF_F803_FE00);
        fork
            collect();
            begin
                ctl.cmd(1'h0, 1'h0, 4'h5, 4'h0, 36'hF_FFFF_FFFF);
                ctl.cmd(1'h0, 1'h0, 4'h5, 4'hA, 36'h0);
                ctl.idle();
                repeat (3) @(negedge clk);
                ctl.cmd(1'h1, 1'h0, 4'h5, 4'hF, 36'h0);
                ctl.idle();
            end
        join
    endtask : t_lane
    task automatic t_burst(input logic lin);
        burst_order_linear = lin;
        fork
            collect();
            begin
                for (int k = 0; k < 4; k++) begin
                    exp_q.push_back(pat(lin ? (1 + k) % 4 : 1 ^ k));
                    ctl.cmd(1'h1, k != 0, 4'h1, 4'hF, 36'h0);
                end
                ctl.idle();
            end
        join
    endtask : t_burst
    task automatic t_stall(input logic slp);
        exp_q.push_back(pat(1));
        fork
            collect();
            begin
                ctl.cmd(1'h1, 1'h0, 4'h1, 4'hF, 36'h0);
                ctl.idle();
                ctl.stall(3, slp);
            end
        join
    endtask : t_stall
    task automatic t_gate();
        for (int j = 0; j < 2; j++) begin
            ctl.chip_select_first_n = (j == 0);
            output_enable_n = (j == 1);
            ctl.cmd(1'h1, 1'h0, 4'h1, 4'hF, 36'h0);
            ctl.idle();
            repeat (6) @(negedge clk) check(36'(data_oe), 36'h0);
        end
        {ctl.chip_select_first_n, output_enable_n} = 2'h0;
    endtask : t_gate
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial begin
        {nrst, output_enable_n, burst_order_linear} = 3'h1;
        repeat (8) @(negedge clk);
        nrst = 1'h1;
        t_rw();
        t_lane();
        t_burst(1'h1);
        t_burst(1'h0);
        t_stall(1'h0);
        t_stall(1'h1);
        t_gate();
        end_of_test();
    end
    // whole run is about 120 cycles
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule : pbsp_port_tb_top
